//--- lucmd_pkg.sv
// lucmd_pkg: constants, field layout and types of the line unit control mode decode
package lucmd_pkg;

   // ----------------
   // control port select codes and path format codes
   // ----------------
   localparam logic [1:0] MODE_HW = 2'h0;      // strap control
   localparam logic [1:0] MODE_SERIAL = 2'h1;  // serial port
   localparam logic [1:0] MODE_MUX_DS = 2'h2;  // muxed port, address strobe / data strobe / read-write select
   localparam logic [1:0] MODE_MUX_ALE = 2'h3; // muxed port, latch enable / read and write strobes / ready
   localparam logic [1:0] PATH_SR_HDB3 = 2'h0; // single rail, hdb3/b8zs coding
   localparam logic [1:0] PATH_SR_AMI = 2'h1;  // single rail, ami coding
   localparam logic [1:0] PATH_DR_CDR = 2'h2;  // dual rail, clock/data recovery on
   localparam logic [1:0] PATH_SLICER = 2'h3;  // dual rail, clock/data recovery bypassed

   // ----------------
   // configuration word layout (straps and software copy alike)
   // ----------------
   localparam int CFG_W = 18;
   localparam int F_PULSE = 0; // pulse_shape_select [3:0]
   localparam int F_TRI = 4; // driver_tristate
   localparam int F_RX_EDGE = 5; // recv_clock_edge_select
   localparam int F_LOOP = 6; // loopback_select [1:0]
   localparam int F_PATTERN = 8; // test_pattern_select [1:0]
   localparam int F_JITTER = 10; // jitter_atten_select [1:0]
   localparam int F_MON = 12; // monitor_gain_select
   localparam int F_TERM = 13; // termination select
   localparam int F_EQUAL = 14; // equalizer_select
   localparam int F_PWR_DOWN = 15; // receiver_power_down
   localparam int F_PATH = 16; // path_format_select [1:0]
   localparam logic [CFG_W-1:0] CFG_RST = 18'h00000;

   // ----------------
   // register map and bus answers
   // ----------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CFG_OFS = 8'h00;  // software configuration
   localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h04; // mode and port status
   localparam logic [ADDR_W-1:0] REG_EFF_OFS = 8'h08;  // configuration in force
   localparam int ST_MODE = 0;    // status: selected mode [1:0]
   localparam int ST_CS = 2;      // status: port select active
   localparam int ST_DUAL = 3;    // status: dual rail
   localparam int ST_AMI = 4;     // status: ami coding
   localparam int ST_CDR = 5;     // status: clock/data recovery on
   localparam int ST_FALL = 6;    // status: falling receive clock edge
   localparam int ST_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // decoded control port mode
   typedef enum logic [1:0] {
      PORT_HW,
      PORT_SERIAL,
      PORT_MUX_DS,
      PORT_MUX_ALE
   } lucmd_mode_type;

endpackage

//--- lucmd_sel_if.sv
// lucmd_sel_if: decoded port selection passed from the decode core to the port mux
`timescale 1ns/1ns
interface lucmd_sel_if;
   logic sel_serial;   // serial port chosen
   logic sel_mux_ds;   // strobe/select muxed port chosen
   logic sel_mux_ale;  // latch/read/write muxed port chosen
   logic cs_active;    // port select pin held low
   modport src (output sel_serial, output sel_mux_ds, output sel_mux_ale, output cs_active);
   modport dst (input sel_serial, input sel_mux_ds, input sel_mux_ale, input cs_active);
endinterface

//--- lucmd_sync.sv
// lucmd_sync: two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ns
module lucmd_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r; // first stage, read only by the second

   // ----------------
   // two stages, frozen while ce is low
   // ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // lucmd_sync

//--- lucmd_port_mux.sv
// lucmd_port_mux: routes the control pins to the port engine per selected mode
`timescale 1ns/1ns
module lucmd_port_mux (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   lucmd_sel_if.dst sel,
   input wire logic [13:0] pins_s,
   input wire logic core_sdo,
   input wire logic core_busy,
   input wire logic core_done,
   input wire logic core_irq,
   input wire logic [7:0] core_ad,
   input wire logic core_ad_drive,
   output logic ser_en,
   output logic ser_sclk,
   output logic ser_edge_fall,
   output logic ser_sdi,
   output logic par_ds_en,
   output logic par_ale_en,
   output logic par_data_or_read_strobe,
   output logic par_rw_or_write_strobe,
   output logic par_address_latch_strobe,
   output logic [7:0] par_ad,
   output logic serial_data_out,
   output logic ack_ready_out,
   output logic int_n_out,
   output logic [7:0] ad_out,
   output logic ad_oe_n
);
   // ----------------
   // port gating
   // ----------------
   wire logic any_par = sel.sel_mux_ds | sel.sel_mux_ale;
   wire logic port_on = sel.sel_serial | any_par;

   assign ser_en = sel.sel_serial & sel.cs_active;
   assign par_ds_en = sel.sel_mux_ds & sel.cs_active;
   assign par_ale_en = sel.sel_mux_ale & sel.cs_active;
   // serial pins: shift clock, edge select, data in
   assign ser_sclk = ser_en & pins_s[0];
   assign ser_edge_fall = sel.sel_serial & pins_s[1];
   assign ser_sdi = ser_en & pins_s[2];
   // parallel pins: strobes, latch, multiplexed address/data
   wire logic par_on = par_ds_en | par_ale_en;
   assign par_data_or_read_strobe = par_on ? pins_s[3] : 1'b1;
   assign par_rw_or_write_strobe = par_on ? pins_s[4] : 1'b1;
   assign par_address_latch_strobe = par_on ? pins_s[5] : 1'b0;
   assign par_ad = par_on ? pins_s[13:6] : 8'h00;

   // ----------------
   // registered pin outputs
   // ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_data_out <= 1'b0;
         ack_ready_out <= 1'b1;
         int_n_out <= 1'b1;
         ad_out <= 8'h00;
         ad_oe_n <= 1'b1;
      end else if (ce) begin
         serial_data_out <= ser_en & core_sdo;
         // acknowledge low when done, or ready low while busy
         if (par_ds_en) begin
            ack_ready_out <= ~core_done;
         end else if (par_ale_en) begin
            ack_ready_out <= ~core_busy;
         end else begin
            ack_ready_out <= 1'b1;
         end
         int_n_out <= ~(port_on & core_irq);
         ad_out <= core_ad;
         ad_oe_n <= ~(par_on & core_ad_drive);
      end
   end
endmodule // lucmd_port_mux

//--- lucmd_top.sv
// lucmd_top: control mode decode, config select and register slave
`timescale 1ns/1ns
module lucmd_top
   import lucmd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // control port select and port select pins
   input wire logic [1:0] mode_sel_pin,
   input wire logic port_select_n,
   // hardware strap pins
   input wire logic [3:0] pulse_shape_select,
   input wire logic driver_tristate,
   input wire logic recv_clock_edge_select,
   input wire logic [1:0] loopback_select,
   input wire logic [1:0] test_pattern_select,
   input wire logic [1:0] jitter_atten_select,
   input wire logic monitor_gain_select,
   input wire logic termination_select,
   input wire logic equalizer_select,
   input wire logic receiver_power_down,
   input wire logic [1:0] path_format_select,
   // microcontroller port pins
   input wire logic shift_clock,
   input wire logic shift_edge_select,
   input wire logic serial_data_in,
   input wire logic data_or_read_strobe,
   input wire logic rw_or_write_strobe,
   input wire logic address_latch_strobe,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   output logic serial_data_out,
   output logic ack_ready_out,
   output logic int_n_out,
   // port engine side
   input wire logic core_sdo,
   input wire logic core_busy,
   input wire logic core_done,
   input wire logic core_irq,
   input wire logic [7:0] core_ad,
   input wire logic core_ad_drive,
   output logic ser_en,
   output logic ser_sclk,
   output logic ser_edge_fall,
   output logic ser_sdi,
   output logic par_ds_en,
   output logic par_ale_en,
   output logic par_data_or_read_strobe,
   output logic par_rw_or_write_strobe,
   output logic par_address_latch_strobe,
   output logic [7:0] par_ad,
   // decoded configuration in force
   output logic hw_mode,
   output logic [CFG_W-1:0] cfg_out,
   output logic rclk_fall_edge,
   output logic dual_rail,
   output logic ami_coding,
   output logic cdr_enable,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------
   // pin synchronisers
   // ----------------
   logic [CFG_W+2:0] strap_s; // {select, port select, straps}
   logic [13:0] pins_s; // {ad, latch, write, read, data in, edge, clock}
   wire logic [CFG_W-1:0] strap_raw = {path_format_select, receiver_power_down, equalizer_select,
      termination_select, monitor_gain_select, jitter_atten_select, test_pattern_select,
      loopback_select, recv_clock_edge_select, driver_tristate, pulse_shape_select};

   lucmd_sync #(.W(CFG_W+3)) u_strap_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d({mode_sel_pin, port_select_n, strap_raw}),
      .q(strap_s)
   );

   lucmd_sync #(.W(14)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d({ad_in, address_latch_strobe, rw_or_write_strobe, data_or_read_strobe,
         serial_data_in, shift_edge_select, shift_clock}),
      .q(pins_s)
   );

   wire logic [1:0] mode_s = strap_s[CFG_W+2:CFG_W+1];
   wire logic cs_n_s = strap_s[CFG_W];
   wire logic [CFG_W-1:0] strap_cfg = strap_s[CFG_W-1:0];

   // ----------------
   // control mode decode
   // ----------------
   lucmd_mode_type mode;   // decoded port mode
   always_comb begin
      case (mode_s)
         MODE_SERIAL: mode = PORT_SERIAL;
         MODE_MUX_DS: mode = PORT_MUX_DS;
         MODE_MUX_ALE: mode = PORT_MUX_ALE;
         default: mode = PORT_HW;
      endcase
   end

   lucmd_sel_if sel_if ();
   assign sel_if.sel_serial = (mode == PORT_SERIAL);
   assign sel_if.sel_mux_ds = (mode == PORT_MUX_DS);
   assign sel_if.sel_mux_ale = (mode == PORT_MUX_ALE);
   assign sel_if.cs_active = ~cs_n_s;
   wire logic hw_sel = (mode == PORT_HW);

   // ----------------
   // port routing
   // ----------------
   lucmd_port_mux u_port_mux (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .sel(sel_if),
      .pins_s(pins_s),
      .core_sdo(core_sdo),
      .core_busy(core_busy),
      .core_done(core_done),
      .core_irq(core_irq),
      .core_ad(core_ad),
      .core_ad_drive(core_ad_drive),
      .ser_en(ser_en),
      .ser_sclk(ser_sclk),
      .ser_edge_fall(ser_edge_fall),
      .ser_sdi(ser_sdi),
      .par_ds_en(par_ds_en),
      .par_ale_en(par_ale_en),
      .par_data_or_read_strobe(par_data_or_read_strobe),
      .par_rw_or_write_strobe(par_rw_or_write_strobe),
      .par_address_latch_strobe(par_address_latch_strobe),
      .par_ad(par_ad),
      .serial_data_out(serial_data_out),
      .ack_ready_out(ack_ready_out),
      .int_n_out(int_n_out),
      .ad_out(ad_out),
      .ad_oe_n(ad_oe_n)
   );

   // ----------------
   // configuration source selection
   // ----------------
   logic [CFG_W-1:0] sw_cfg_r; // software copy of the configuration
   // software mode ignores the receive edge pin
   wire logic [CFG_W-1:0] eff_cfg = hw_sel ? strap_cfg : sw_cfg_r;
   wire logic [1:0] eff_path = eff_cfg[F_PATH+1:F_PATH];
   wire logic eff_fall = eff_cfg[F_RX_EDGE];
   wire logic eff_dual = (eff_path == PATH_DR_CDR) | (eff_path == PATH_SLICER);
   wire logic eff_ami = (eff_path == PATH_SR_AMI);
   wire logic eff_cdr = (eff_path != PATH_SLICER);

   // registered copies of the configuration in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hw_mode <= 1'b1;
         cfg_out <= CFG_RST;
         rclk_fall_edge <= 1'b0;
         dual_rail <= 1'b0;
         ami_coding <= 1'b0;
         cdr_enable <= 1'b1;
      end else if (ce) begin
         hw_mode <= hw_sel;
         cfg_out <= eff_cfg;
         rclk_fall_edge <= eff_fall;
         dual_rail <= eff_dual;
         ami_coding <= eff_ami;
         cdr_enable <= eff_cdr;
      end
   end

   // ----------------
   // axi4-lite write channel
   // ----------------
   logic aw_got_r;                // write address held
   logic w_got_r;                 // write data held
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   assign s_axi_awready = ~aw_got_r & ~bvalid_r;
   assign s_axi_wready = ~w_got_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   wire logic wr_go = aw_got_r & w_got_r & ~bvalid_r;
   wire logic wr_cfg = wr_go & (awaddr_r == REG_CFG_OFS);
   wire logic wr_ro = wr_go & ((awaddr_r == REG_STAT_OFS) | (awaddr_r == REG_EFF_OFS));

   // byte-lane merge of the software configuration
   logic [CFG_W-1:0] sw_cfg_nxt;
   always_comb begin
      sw_cfg_nxt = sw_cfg_r;
      if (wstrb_r[0]) begin
         sw_cfg_nxt[7:0] = wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
         sw_cfg_nxt[15:8] = wdata_r[15:8];
      end
      if (wstrb_r[2]) begin
         sw_cfg_nxt[17:16] = wdata_r[17:16];
      end
   end

   // address/data capture in either order, then one response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         sw_cfg_r <= CFG_RST;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (wr_cfg | wr_ro) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r & s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (wr_cfg) begin
            sw_cfg_r <= sw_cfg_nxt;
         end
      end
   end

   // ----------------
   // axi4-lite read channel
   // ----------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   wire logic [ADDR_W-1:0] ar_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
   wire logic [ST_W-1:0] status_v = {eff_fall, eff_cdr, eff_ami, eff_dual, ~cs_n_s, mode_s};
   wire logic ar_cfg = (ar_word == REG_CFG_OFS);
   wire logic ar_stat = (ar_word == REG_STAT_OFS);
   wire logic ar_eff = (ar_word == REG_EFF_OFS);
   // read data select by address
   wire logic [31:0] rd_sel = ar_cfg ? {14'h0000, sw_cfg_r}
                            : ar_stat ? {25'h0000000, status_v}
                            : ar_eff ? {14'h0000, eff_cfg}
                            : 32'h00000000;

   // one read at a time, answered one edge after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid & ~rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_sel;
            rresp_r <= (ar_cfg | ar_stat | ar_eff) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // protection bits carry no meaning here
   wire logic unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule // lucmd_top

//--- lucmd_monitor.sv
// lucmd_monitor: port level checks of the control mode decode
`timescale 1ns/1ns
module lucmd_monitor
   import lucmd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] mode_sel_pin,
   input wire logic port_select_n,
   input wire logic shift_edge_select,
   input wire logic [7:0] ad_in,
   input wire logic recv_clock_edge_select,
   input wire logic [1:0] path_format_select,
   input wire logic ser_en,
   input wire logic ser_edge_fall,
   input wire logic par_ds_en,
   input wire logic par_ale_en,
   input wire logic [7:0] par_ad,
   input wire logic hw_mode,
   input wire logic [CFG_W-1:0] cfg_out,
   input wire logic rclk_fall_edge,
   input wire logic dual_rail,
   input wire logic ami_coding,
   input wire logic cdr_enable
);
   // ----------------
   // edges since reset; pin history is trusted from 2 (ports) or 3 (decode)
   // ----------------
   logic [1:0] up_r; // saturating edge count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // strap mode seen three edges ago, decode outputs due now
   sequence strap_seen;
      &up_r && $past(mode_sel_pin, 3) == MODE_HW;
   endsequence
   AST_SERIAL_EN: assert property (up_r[1] |-> ser_en == ($past(mode_sel_pin, 2) == MODE_SERIAL
      && !$past(port_select_n, 2))) else $error("serial enable wrong");
   AST_MUX_DS_EN: assert property (up_r[1] |-> par_ds_en == ($past(mode_sel_pin, 2) == MODE_MUX_DS
      && !$past(port_select_n, 2))) else $error("strobe port enable wrong");
   AST_MUX_ALE_EN: assert property (up_r[1] |-> par_ale_en == ($past(mode_sel_pin, 2) == MODE_MUX_ALE
      && !$past(port_select_n, 2))) else $error("latch port enable wrong");
   AST_SEL_IGNORE: assert property (port_select_n [*3] ##0 up_r[1] |-> !(ser_en || par_ds_en || par_ale_en))
      else $error("port enabled while deselected");
   AST_SHIFT_EDGE: assert property (up_r[1] && ser_en |-> ser_edge_fall == $past(shift_edge_select, 2))
      else $error("shift edge wrong");
   AST_PAR_BUS: assert property (up_r[1] && (par_ds_en || par_ale_en) |-> par_ad == $past(ad_in, 2))
      else $error("bus data wrong");
   AST_HW_MODE: assert property (&up_r |-> hw_mode == ($past(mode_sel_pin, 3) == MODE_HW))
      else $error("strap mode flag wrong");
   AST_STRAP_CFG: assert property (strap_seen |-> cfg_out[F_PATH +: 2] == $past(path_format_select, 3))
      else $error("strap config wrong");
   AST_RCLK_EDGE: assert property (strap_seen |-> rclk_fall_edge == $past(recv_clock_edge_select, 3))
      else $error("receive clock edge wrong");
   AST_PATH_SINGLE: assert property (strap_seen ##0 $past(path_format_select, 3) < 2'h2 |-> !dual_rail
      && cdr_enable && ami_coding == ($past(path_format_select, 3) == PATH_SR_AMI)) else $error("single rail");
   AST_PATH_DUAL: assert property (strap_seen ##0 $past(path_format_select, 3) > 2'h1 |-> dual_rail
      && !ami_coding && cdr_enable == ($past(path_format_select, 3) == PATH_DR_CDR)) else $error("dual rail");
   C_SERIAL: cover property (ser_en && ser_edge_fall);
   C_ALE: cover property (par_ale_en);
   C_SLICER: cover property (hw_mode && !cdr_enable);
endmodule // lucmd_monitor

bind lucmd_top lucmd_monitor i_lucmd_monitor (.aclk, .aresetn, .mode_sel_pin, .port_select_n, .shift_edge_select,
   .ad_in, .recv_clock_edge_select, .path_format_select, .ser_en, .ser_edge_fall, .par_ds_en, .par_ale_en,
   .par_ad, .hw_mode, .cfg_out, .rclk_fall_edge, .dual_rail, .ami_coding, .cdr_enable);

//--- lucmd_partner.sv
// lucmd_partner: microcontroller and strap levels facing the decode block
`timescale 1ns/1ns
module lucmd_partner
   import lucmd_pkg::*;
(
   input wire logic aclk,
   output logic [1:0] mode_sel_pin,
   output logic port_select_n,
   output logic [CFG_W-1:0] strap,
   output logic [13:0] pins
);
   // power-up: strap mode, port deselected
   initial begin
      mode_sel_pin = MODE_HW;
      port_select_n = 1'b1;
      strap = CFG_RST;
      pins = 14'h0000;
   end
   // new levels just after an edge; port pins are junk while deselected
   task automatic drive(input logic [1:0] m, input logic sn, input logic [CFG_W-1:0] s, input logic [13:0] p);
      @(posedge aclk);
      mode_sel_pin <= m;
      port_select_n <= sn;
      strap <= (m == MODE_HW) ? s : (s & ~18'h00020);
      pins <= sn ? ~pins : p;
   endtask
endmodule // lucmd_partner

//--- lucmd_top_tb.sv
// lucmd_top_tb: self-checking bench of the control mode decode
`timescale 1ns/1ns
module lucmd_top_tb
   import lucmd_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, core_sdo = 1'b0, core_irq = 1'b0, core_flag = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, par_ad, ad_out;
   logic [2:0] strb;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] mode_sel_pin, bresp, rresp;
   logic [CFG_W-1:0] strap, cfg_out;
   logic [13:0] pins;
   logic port_select_n, ser_en, ser_sclk, ser_edge_fall, ser_sdi, par_ds_en, par_ale_en, hw_mode, rclk_fall_edge;
   logic dual_rail, ami_coding, cdr_enable, serial_data_out, ack_ready_out, int_n_out;
   logic awready, wready, bvalid, arready, rvalid, ad_oe_n;
   int n_fail = 0;
   int n_checks = 0;
   // 250 MHz clock
   always #2 aclk = ~aclk;
   lucmd_partner i_lucmd_partner (.aclk, .mode_sel_pin, .port_select_n, .strap, .pins);
   lucmd_top i_lucmd_top (.aclk, .aresetn, .ce(1'b1), .mode_sel_pin, .port_select_n,
      .pulse_shape_select(strap[3:0]), .driver_tristate(strap[F_TRI]), .recv_clock_edge_select(strap[F_RX_EDGE]),
      .loopback_select(strap[7:6]), .test_pattern_select(strap[9:8]), .jitter_atten_select(strap[11:10]),
      .monitor_gain_select(strap[F_MON]), .termination_select(strap[F_TERM]), .equalizer_select(strap[F_EQUAL]),
      .receiver_power_down(strap[F_PWR_DOWN]), .path_format_select(strap[17:16]), .shift_clock(pins[0]),
      .shift_edge_select(pins[1]), .serial_data_in(pins[2]), .data_or_read_strobe(pins[3]),
      .rw_or_write_strobe(pins[4]), .address_latch_strobe(pins[5]), .ad_in(pins[13:6]), .ad_out, .ad_oe_n,
      .serial_data_out, .ack_ready_out, .int_n_out, .core_sdo, .core_busy(core_flag), .core_done(core_irq),
      .core_irq, .core_ad(8'h3C), .core_ad_drive(core_flag), .ser_en, .ser_sclk, .ser_edge_fall, .ser_sdi,
      .par_ds_en, .par_ale_en, .par_data_or_read_strobe(strb[2]), .par_rw_or_write_strobe(strb[1]),
      .par_address_latch_strobe(strb[0]), .par_ad,
      .hw_mode, .cfg_out, .rclk_fall_edge, .dual_rail, .ami_coding, .cdr_enable, .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // ----------------
   // compare, wait and bus tasks
   // ----------------
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pins need three edges to reach the decode outputs
   task automatic settle;
      repeat (5) @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_hw;
      logic [2:0] dec [4] = '{3'h1, 3'h3, 3'h5, 3'h4}; // dual, ami, cdr per path code
      logic [CFG_W-1:0] s;
      for (int p = 0; p < 4; p++) begin
         s = {p[1:0], 16'h0000} | (p[0] ? 18'h00025 : 18'h0C00A);
         i_lucmd_partner.drive(MODE_HW, 1'b1, s, 14'h0000);
         settle();
         chk({hw_mode, rclk_fall_edge}, {1'b1, s[F_RX_EDGE]});
         chk(cfg_out, s);
         chk({dual_rail, ami_coding, cdr_enable}, dec[p]);
      end
      $display("strap mode test done");
   endtask
   task automatic t_modes;
      logic [1:0] m;
      logic [2:0] e;
      for (int k = 2; k < 8; k++) begin
         m = k[2:1];
         e = {m == MODE_SERIAL, m == MODE_MUX_DS, m == MODE_MUX_ALE} & {3{!k[0]}};
         i_lucmd_partner.drive(m, k[0], 18'h00000, 14'h0000);
         settle();
         chk({ser_en, par_ds_en, par_ale_en}, e);
         chk(hw_mode, 1'b0);
      end
      $display("port select test done");
   endtask
   task automatic t_ser;
      core_sdo <= 1'b1;
      core_irq <= 1'b1;
      for (int e = 0; e < 2; e++) begin
         i_lucmd_partner.drive(MODE_SERIAL, 1'b0, 18'h00000, {11'h000, 1'b1, e[0], 1'b1});
         settle();
         chk({ser_sclk, ser_sdi, ser_edge_fall}, {2'h3, e[0]});
         chk({serial_data_out, int_n_out}, 2'h2);
      end
      core_sdo <= 1'b0;
      core_irq <= 1'b0;
      $display("serial port test done");
   endtask
   task automatic t_par;
      core_flag <= 1'b1;
      for (int m = 2; m < 4; m++) begin
         i_lucmd_partner.drive(m[1:0], 1'b0, 18'h00000, 14'h2968);
         settle();
         chk({par_ad, ack_ready_out, strb}, {8'hA5, !m[0], 3'h5});
         chk({ad_oe_n, ad_out}, 9'h03C);
         i_lucmd_partner.drive(m[1:0], 1'b1, 18'h00000, 14'h2968);
         settle();
         chk({par_ad, ad_oe_n, strb}, {8'h00, 1'b1, 3'h6});
      end
      core_flag <= 1'b0;
      $display("parallel port test done");
   endtask
   task automatic t_sw;
      logic [31:0] d;
      logic [1:0] r;
      i_lucmd_partner.drive(MODE_SERIAL, 1'b0, 18'h3FFFF, 14'h0000);
      axi_wr(REG_CFG_OFS, 32'h00030020, r);
      settle();
      chk({r, hw_mode, rclk_fall_edge, dual_rail, cdr_enable}, {RESP_OKAY, 4'h6});
      axi_rd(REG_EFF_OFS, d, r);
      chk({r, d}, {RESP_OKAY, 32'h00030020});
      axi_rd(REG_STAT_OFS, d, r);
      chk({r, d}, {RESP_OKAY, 32'h0000004D});
      axi_wr(8'h40, 32'h00000001, r);
      chk(r, RESP_SLVERR);
      axi_rd(8'h40, d, r);
      chk({r, d}, {RESP_SLVERR, 32'h00000000});
      $display("software mode test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence: reset values, then each scenario
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (4) @(posedge aclk);
      chk({hw_mode, cdr_enable, awready, bvalid, rvalid}, 5'h1C);
      @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(REG_CFG_OFS, d, r);
      chk({r, d}, {RESP_OKAY, 32'h00000000});
      $display("reset test done");
      t_hw();
      t_modes();
      t_ser();
      t_par();
      t_sw();
      results();
   end
   // a hang outlasts the run over twentyfold
   initial begin
      repeat (3000) @(posedge aclk);
      n_fail++;
      results();
   end
endmodule // lucmd_top_tb
